//--- common/rcw_pkg.sv
// Shared constants and types for the reset-cause and watchdog block
package rcw_pkg;

	// ========================================
	// Register indices and common values
	typedef logic [7:0] rcw_byte_t;
	localparam logic [1:0] RCW_REG_CAUSE = 2'h0;
	localparam logic [1:0] RCW_REG_FRC   = 2'h1;
	localparam logic [1:0] RCW_REG_OPT1  = 2'h2;
	localparam logic [1:0] RCW_REG_OPT2  = 2'h3;
	localparam rcw_byte_t  RCW_ZERO      = 8'h00;
	localparam rcw_byte_t  RCW_SVC_FIRST = 8'h55;
	localparam rcw_byte_t  RCW_SVC_LAST  = 8'haa;

	// ========================================
	// Cause flag positions and power-on image
	localparam int RCW_B_POR  = 7;
	localparam int RCW_B_PIN  = 6;
	localparam int RCW_B_WDT  = 5;
	localparam int RCW_B_ILLEGAL_OPCODE_FLAG = 4;
	localparam int RCW_B_ILLEGAL_ADDRESS_FLAG = 3;
	localparam int RCW_B_LOC  = 2;
	localparam int RCW_B_LVD  = 1;
	localparam rcw_byte_t RCW_POR_FLAGS = 8'h82;

	// ========================================
	// Option fields, reset values, writable masks
	localparam int RCW_B_TMO_HI = 7;
	localparam int RCW_B_TMO_LO = 6;
	localparam int RCW_B_STOP   = 5;
	localparam int RCW_B_TWI    = 3;
	localparam int RCW_B_WCLK   = 7;
	localparam int RCW_B_WWIN   = 6;
	localparam int RCW_B_FRC    = 0;
	localparam rcw_byte_t RCW_OPT1_RST  = 8'hc0;
	localparam rcw_byte_t RCW_OPT1_MASK = 8'he8;
	localparam rcw_byte_t RCW_OPT2_RST  = 8'h00;
	localparam rcw_byte_t RCW_OPT2_MASK = 8'hc0;

	// ========================================
	// Watchdog timing
	localparam int RCW_CW = 18;
	localparam logic [1:0] RCW_TMO_OFF   = 2'h0;
	localparam logic [1:0] RCW_TMO_SHORT = 2'h1;
	localparam logic [1:0] RCW_TMO_MID   = 2'h2;
	localparam int RCW_LPO_PERIOD_US = 1000;
	localparam int RCW_TMO1_US = 32000;
	localparam int RCW_TMO2_US = 256000;
	localparam int RCW_TMO3_US = 1024000;
	localparam logic [RCW_CW-1:0] RCW_LPO_LAST1 =
		RCW_CW'(RCW_TMO1_US / RCW_LPO_PERIOD_US - 1);
	localparam logic [RCW_CW-1:0] RCW_LPO_LAST2 =
		RCW_CW'(RCW_TMO2_US / RCW_LPO_PERIOD_US - 1);
	localparam logic [RCW_CW-1:0] RCW_LPO_LAST3 =
		RCW_CW'(RCW_TMO3_US / RCW_LPO_PERIOD_US - 1);

	// ========================================
	// Reset sequencer
	localparam logic [3:0] RCW_HOLD_CYC = 4'hf;
	typedef enum logic [1:0] {
		RCW_RUN  = 2'b00,
		RCW_HOLD = 2'b01
	} rcw_state_t;

endpackage

//--- rtl/rcw_sync3.sv
// Three-stage synchroniser that passes a level once stages two and three agree
module rcw_sync3 #(
	parameter int         W   = 4,
	parameter logic [3:0] RST = 4'h0
) (
	input  wire logic         ref_clk,
	input  wire logic         rst_b,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);

	// ========================================
	// One chain per input bit
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			logic ff1;
			logic ff2;
			logic ff3;
			// Output moves only on agreement, so one glitch never counts
			always_ff @(posedge ref_clk or negedge rst_b) begin
				if (!rst_b) begin
					ff1     <= RST[i];
					ff2     <= RST[i];
					ff3     <= RST[i];
					dout[i] <= RST[i];
				end else begin
					ff1 <= din[i];
					ff2 <= ff1;
					ff3 <= ff2;
					if (ff2 == ff3) begin
						dout[i] <= ff3;
					end
				end
			end
		end
	endgenerate

endmodule

//--- rtl/rcw_wdog.sv
// Watchdog counter with per-source overflow point and service window
module rcw_wdog #(
	parameter int OVF1 = 8192,
	parameter int OVF2 = 65536,
	parameter int OVF3 = 262144,
	parameter int WIN1 = 6144,
	parameter int WIN2 = 49152,
	parameter int WIN3 = 196608
) (
	input  wire logic       ref_clk,
	input  wire logic       rst_b,
	input  wire logic       restart,
	input  wire logic       tick,
	input  wire logic       use_bus,
	input  wire logic [1:0] sel,
	output logic            ovf,
	output logic            window_open
);
	import rcw_pkg::*;

	logic [RCW_CW-1:0] cnt;
	wire logic [RCW_CW-1:0] lpo_last;
	wire logic [RCW_CW-1:0] bus_last;
	wire logic [RCW_CW-1:0] open_cnt;
	wire logic [RCW_CW-1:0] last_cnt;
	wire logic              enabled;

	// ========================================
	// Overflow point by source and timeout code
	assign enabled  = (sel != RCW_TMO_OFF);
	assign lpo_last = (sel == RCW_TMO_SHORT) ? RCW_LPO_LAST1 :
		(sel == RCW_TMO_MID) ? RCW_LPO_LAST2 : RCW_LPO_LAST3;
	assign bus_last = (sel == RCW_TMO_SHORT) ? RCW_CW'(OVF1 - 1) :
		(sel == RCW_TMO_MID) ? RCW_CW'(OVF2 - 1) :
		RCW_CW'(OVF3 - 1);
	assign open_cnt = (sel == RCW_TMO_SHORT) ? RCW_CW'(WIN1) :
		(sel == RCW_TMO_MID) ? RCW_CW'(WIN2) : RCW_CW'(WIN3);
	assign last_cnt = use_bus ? bus_last : lpo_last;
	assign ovf      = enabled && tick && (cnt == last_cnt);
	// Window has no meaning on the slow clock or when disabled
	assign window_open = !enabled || !use_bus || (cnt >= open_cnt);

	// Counter wraps at overflow; the reset that follows restarts it anyway
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt <= '0;
		end else if (restart) begin
			cnt <= '0;
		end else if (enabled && tick) begin
			cnt <= ovf ? '0 : cnt + 1'b1;
		end
	end

endmodule

//--- rtl/rcw_top.sv
// Reset-cause capture, forced reset, write-once options and watchdog
module rcw_top #(
	parameter int WD_BUS_OVF1 = 8192,
	parameter int WD_BUS_OVF2 = 65536,
	parameter int WD_BUS_OVF3 = 262144,
	parameter int WD_WIN1     = 6144,
	parameter int WD_WIN2     = 49152,
	parameter int WD_WIN3     = 196608
) (
	input  wire logic              ref_clk,
	input  wire logic              rst_b,
	input  wire logic              ext_reset_pin_b,
	input  wire logic              lvd_trip,
	input  wire logic              clk_lost,
	input  wire logic              lpo_clk,
	input  wire logic              low_voltage_reset_en,
	input  wire logic              background_halt_allow,
	input  wire logic              illegal_opcode,
	input  wire logic              illegal_address,
	input  wire logic              stop_exec,
	input  wire logic              debug_halt_instr,
	input  wire logic [1:0]        reg_addr,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	input  wire logic              reg_bdm,
	input  wire rcw_pkg::rcw_byte_t reg_wdata,
	output rcw_pkg::rcw_byte_t     reg_rdata,
	output logic                   mcu_rst_b,
	output logic                   stop_enter,
	output logic                   halt_enter,
	output logic                   twi_pin_route
);
	import rcw_pkg::*;

	// ========================================
	// State
	rcw_state_t state;
	logic [3:0] hold_cnt;
	rcw_byte_t  flags;
	rcw_byte_t  opt1;
	rcw_byte_t  opt2;
	logic       opt1_lock;
	logic       opt2_lock;
	logic       armed;
	logic       lpo_prev;

	// ========================================
	// Pin synchronisers
	wire logic [3:0] sync_q;
	wire logic       s_pin_b;
	wire logic       s_lvd;
	wire logic       s_loc;
	wire logic       s_lpo;

	rcw_sync3 #(
		.W   (4),
		.RST (4'h1)
	) u_sync (
		.ref_clk (ref_clk),
		.rst_b   (rst_b),
		.din     ({lpo_clk, clk_lost, lvd_trip, ext_reset_pin_b}),
		.dout    (sync_q)
	);

	assign s_pin_b = sync_q[0];
	assign s_lvd   = sync_q[1];
	assign s_loc   = sync_q[2];
	assign s_lpo   = sync_q[3];

	// ========================================
	// Register decode
	wire logic in_run;
	wire logic wr_ok;
	wire logic wr_cause;
	wire logic wr_frc;
	wire logic wr_opt1;
	wire logic wr_opt2;
	wire logic frc_req;

	// Register writes are dropped while the device sits in reset; reads still update reg_rdata
	assign in_run   = (state == RCW_RUN);
	assign wr_ok    = in_run && reg_wr;
	assign wr_cause = wr_ok && (reg_addr == RCW_REG_CAUSE);
	assign wr_frc   = wr_ok && (reg_addr == RCW_REG_FRC);
	assign wr_opt1  = wr_ok && (reg_addr == RCW_REG_OPT1);
	assign wr_opt2  = wr_ok && (reg_addr == RCW_REG_OPT2);
	// User-program writes never reach the force bit
	assign frc_req  = wr_frc && reg_bdm && reg_wdata[RCW_B_FRC];

	// ========================================
	// Option fields
	wire logic [1:0] tmo_sel;
	wire logic       stop_allow;
	wire logic       use_bus;
	wire logic       win_mode;
	wire logic       wd_en;

	assign tmo_sel    = opt1[RCW_B_TMO_HI:RCW_B_TMO_LO];
	assign stop_allow = opt1[RCW_B_STOP];
	assign use_bus    = opt2[RCW_B_WCLK];
	// Window only applies when the bus clock drives the counter
	assign win_mode   = opt2[RCW_B_WWIN] && use_bus;
	assign wd_en      = (tmo_sel != RCW_TMO_OFF);
	assign twi_pin_route = opt1[RCW_B_TWI];

	// ========================================
	// Watchdog service and counter
	wire logic lpo_tick;
	wire logic wd_tick;
	wire logic wd_ovf;
	wire logic win_open;
	wire logic win_viol;
	wire logic bad_val;
	wire logic svc_done;

	// Slow clock is sampled, so it must stay well below ref_clk
	assign lpo_tick = s_lpo && !lpo_prev;
	assign wd_tick  = use_bus ? 1'b1 : lpo_tick;
	assign win_viol = wr_cause && win_mode && !win_open;
	assign bad_val  = wr_cause && wd_en && (reg_wdata != RCW_SVC_FIRST) &&
		(reg_wdata != RCW_SVC_LAST);
	assign svc_done = wr_cause && armed && !win_viol &&
		(reg_wdata == RCW_SVC_LAST);

	rcw_wdog #(
		.OVF1 (WD_BUS_OVF1),
		.OVF2 (WD_BUS_OVF2),
		.OVF3 (WD_BUS_OVF3),
		.WIN1 (WD_WIN1),
		.WIN2 (WD_WIN2),
		.WIN3 (WD_WIN3)
	) u_wdog (
		.ref_clk     (ref_clk),
		.rst_b       (rst_b),
		.restart     (!in_run || svc_done),
		.tick        (wd_tick),
		.use_bus     (use_bus),
		.sel         (tmo_sel),
		.ovf         (wd_ovf),
		.window_open (win_open)
	);

	// Sequence arms on 0x55 and is consumed by the next cause write
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			armed    <= 1'b0;
			lpo_prev <= 1'b0;
		end else begin
			lpo_prev <= s_lpo;
			if (!in_run) begin
				armed <= 1'b0;
			end else if (wr_cause) begin
				armed <= (reg_wdata == RCW_SVC_FIRST);
			end
		end
	end

	// ========================================
	// Reset sources
	rcw_byte_t  cause_vec;
	wire logic  illegal_opcode_flag_src;
	wire logic  any_src;

	assign illegal_opcode_flag_src = illegal_opcode ||
		(stop_exec && !stop_allow) ||
		(debug_halt_instr && !background_halt_allow);

	// Image of all sources active now except the force request; power-on only comes via rst_b
	always_comb begin
		cause_vec             = RCW_ZERO;
		cause_vec[RCW_B_PIN]  = !s_pin_b;
		cause_vec[RCW_B_WDT]  = wd_ovf || win_viol || bad_val;
		cause_vec[RCW_B_ILLEGAL_OPCODE_FLAG] = illegal_opcode_flag_src;
		cause_vec[RCW_B_ILLEGAL_ADDRESS_FLAG] = illegal_address;
		cause_vec[RCW_B_LOC]  = s_loc;
		cause_vec[RCW_B_LVD]  = s_lvd && low_voltage_reset_en;
	end

	assign any_src    = (cause_vec != RCW_ZERO) || frc_req;
	assign stop_enter = in_run && stop_exec && stop_allow;
	assign halt_enter = in_run && debug_halt_instr && background_halt_allow;
	assign mcu_rst_b  = in_run;

	// ========================================
	// Reset sequencer and cause flags
	// Flags are loaded only on entry so the cause survives its own reset
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			state    <= RCW_HOLD;
			hold_cnt <= RCW_HOLD_CYC;
			flags    <= RCW_POR_FLAGS;
		end else begin
			case (state)
				RCW_RUN: begin
					if (any_src) begin
						state    <= RCW_HOLD;
						hold_cnt <= RCW_HOLD_CYC;
						flags    <= cause_vec;
					end
				end
				RCW_HOLD: begin
					if (hold_cnt != 4'h0) begin
						hold_cnt <= hold_cnt - 4'h1;
					end else if (s_pin_b) begin
						state <= RCW_RUN;
					end
				end
				default: begin
					state <= RCW_HOLD;
				end
			endcase
		end
	end

	// ========================================
	// Write-once option registers
	// Any reset reloads defaults and reopens the single write
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			opt1      <= RCW_OPT1_RST;
			opt2      <= RCW_OPT2_RST;
			opt1_lock <= 1'b0;
			opt2_lock <= 1'b0;
		end else if (!in_run) begin
			opt1      <= RCW_OPT1_RST;
			opt2      <= RCW_OPT2_RST;
			opt1_lock <= 1'b0;
			opt2_lock <= 1'b0;
		end else begin
			if (wr_opt1 && !opt1_lock) begin
				opt1      <= reg_wdata & RCW_OPT1_MASK;
				opt1_lock <= 1'b1;
			end
			if (wr_opt2 && !opt2_lock) begin
				opt2      <= reg_wdata & RCW_OPT2_MASK;
				opt2_lock <= 1'b1;
			end
		end
	end

	// ========================================
	// Read data
	wire rcw_byte_t read_val;

	assign read_val = (reg_addr == RCW_REG_CAUSE) ? flags :
		(reg_addr == RCW_REG_OPT1) ? opt1 :
		(reg_addr == RCW_REG_OPT2) ? opt2 : RCW_ZERO;

	// Registered so the read port never glitches
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata <= RCW_ZERO;
		end else if (reg_rd) begin
			reg_rdata <= read_val;
		end
	end

	// ========================================
	// Checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);

	frc_read_zero_a: assert property (
		reg_rd && reg_addr == RCW_REG_FRC |=> reg_rdata == RCW_ZERO)
		else $error("force register read not zero");

	frc_user_a: assert property (
		wr_frc && !reg_bdm && cause_vec == RCW_ZERO |=> in_run)
		else $error("user write to force register caused reset");

	bdm_force_a: assert property (
		in_run && frc_req && cause_vec == RCW_ZERO
		|=> !mcu_rst_b && flags == RCW_ZERO)
		else $error("debug force reset wrong");

	opt_once_a: assert property (
		wr_opt1 && opt1_lock |=> $stable(opt1))
		else $error("locked options register changed");

	stop_illegal_opcode_flag_a: assert property (
		in_run && stop_exec && !stop_allow
		|=> !mcu_rst_b && flags[RCW_B_ILLEGAL_OPCODE_FLAG] ##1 !mcu_rst_b)
		else $error("disallowed stop did not reset");

	debug_halt_instr_illegal_opcode_flag_a: assert property (
		in_run && debug_halt_instr && !background_halt_allow
		|=> flags[RCW_B_ILLEGAL_OPCODE_FLAG] && !halt_enter)
		else $error("disallowed halt did not reset");

	wd_off_a: assert property (
		tmo_sel == RCW_TMO_OFF |-> !cause_vec[RCW_B_WDT])
		else $error("disabled watchdog requested reset");

	win_early_a: assert property (
		in_run && wr_cause && win_mode && !win_open
		|=> flags[RCW_B_WDT] && !mcu_rst_b)
		else $error("early window write did not reset");

	pin_flag_a: assert property (
		in_run && !s_pin_b |=> flags[RCW_B_PIN] && state == RCW_HOLD)
		else $error("pin reset flag missing");

	loc_flag_a: assert property (
		in_run && any_src |=> flags[RCW_B_LOC] == $past(s_loc))
		else $error("clock loss flag wrong");

endmodule

//--- bench/tb.sv
// Self-checking bench for the reset-cause, options and watchdog block
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import rcw_pkg::*;

	// ========================================
	// Stimulus and observed signals
	logic       ref_clk, rst_b, ext_reset_pin_b, lvd_trip, clk_lost;
	logic       lpo_clk, low_voltage_reset_en, background_halt_allow;
	logic       illegal_opcode, illegal_address, stop_exec;
	logic       debug_halt_instr, reg_wr, reg_rd, reg_bdm;
	logic [1:0] reg_addr;
	rcw_byte_t  reg_wdata, reg_rdata;
	logic       mcu_rst_b, stop_enter, halt_enter, twi_pin_route;
	logic       seen_stop, seen_halt;
	int         fail_count, n_tests, n;
	// Expected cause images, one per source in the source table
	rcw_byte_t  exp_c [7] = '{8'h10, 8'h08, 8'h10, 8'h10, 8'h04, 8'h02, 8'h40};

	// Shortened bus counts keep the 3/4 window ratio; the code 3 window
	// is never used here, so it keeps its default
	rcw_top #(
		.WD_BUS_OVF1(64), .WD_BUS_OVF2(128), .WD_BUS_OVF3(256),
		.WD_WIN1(48), .WD_WIN2(96)
	) i_rcw_top (
		.ref_clk(ref_clk), .rst_b(rst_b), .ext_reset_pin_b(ext_reset_pin_b),
		.lvd_trip(lvd_trip), .clk_lost(clk_lost), .lpo_clk(lpo_clk),
		.low_voltage_reset_en(low_voltage_reset_en),
		.background_halt_allow(background_halt_allow),
		.illegal_opcode(illegal_opcode), .illegal_address(illegal_address),
		.stop_exec(stop_exec), .debug_halt_instr(debug_halt_instr),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_bdm(reg_bdm), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.mcu_rst_b(mcu_rst_b), .stop_enter(stop_enter),
		.halt_enter(halt_enter), .twi_pin_route(twi_pin_route)
	);

	// ========================================
	// Clocks: slow clock sped up to about 8 cycles a tick, free phase
	always #20 ref_clk = ~ref_clk;
	always #163 lpo_clk = ~lpo_clk;

	// ========================================
	// Compare and verdict tasks
	task automatic chkb(input string s, input logic e, input logic g);
		n_tests++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] %s expected %b seen %b", s, e, g);
		end
	endtask

	task automatic chk8(input string s, input rcw_byte_t e, input rcw_byte_t g);
		n_tests++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", s, e, g);
		end
	endtask

	task automatic chkr(input string s, input int lo, input int hi, input int g);
		n_tests++;
		if (g < lo || g > hi) begin
			fail_count++;
			$display("[ERR] %s expected %0d..%0d seen %0d", s, lo, hi, g);
		end
	endtask

	task automatic give_verdict();
		if (fail_count == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// ========================================
	// Register access: strobes last one cycle, a spare edge between calls
	task automatic wr(input logic [1:0] a, input rcw_byte_t d, input logic b);
		@(negedge ref_clk);
		reg_addr = a;
		reg_wdata = d;
		reg_bdm = b;
		reg_wr = 1'b1;
		@(negedge ref_clk);
		reg_wr = 1'b0;
		reg_bdm = 1'b0;
	endtask

	task automatic rdc(input logic [1:0] a, input rcw_byte_t e, input string s);
		@(negedge ref_clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge ref_clk);
		reg_rd = 1'b0;
		chk8(s, e, reg_rdata);
	endtask

	task automatic svc();
		wr(2'h0, 8'h55, 1'b0);
		wr(2'h0, 8'haa, 1'b0);
	endtask

	// ========================================
	// Reset waits, bounded so a stuck design cannot hang the run
	task automatic wait_rst(input int bound);
		n = 0;
		while (mcu_rst_b !== 1'b0 && n < bound) begin
			@(negedge ref_clk);
			n++;
		end
		chkb("reset entered", 1'b0, mcu_rst_b);
	endtask

	task automatic wait_run();
		n = 0;
		while (mcu_rst_b !== 1'b1 && n < 80) begin
			@(negedge ref_clk);
			n++;
		end
		chkb("reset left", 1'b1, mcu_rst_b);
	endtask

	// Cycles from now until the watchdog pulls reset
	task automatic wd_time(output int c);
		c = 0;
		while (mcu_rst_b === 1'b1 && c < 12000) begin
			@(negedge ref_clk);
			c++;
		end
	endtask

	// ========================================
	// Reset sources: pulses last one cycle, levels six
	task automatic src(input int k, input logic v);
		case (k)
			0: illegal_opcode = v;
			1: illegal_address = v;
			2: stop_exec = v;
			3: debug_halt_instr = v;
			4: clk_lost = v;
			5: lvd_trip = v;
			default: ext_reset_pin_b = ~v;
		endcase
	endtask

	task automatic fire(input int k);
		@(negedge ref_clk);
		src(k, 1'b1);
		#1;
		seen_stop = stop_enter;
		seen_halt = halt_enter;
		repeat (k > 3 ? 6 : 1) @(negedge ref_clk);
		src(k, 1'b0);
	endtask

	// ========================================
	// Watchdog cuts a hang short well past the expected run length
	initial begin
		#(40 * 40000);
		fail_count++;
		give_verdict();
	end

	// ========================================
	// Main sequence
	initial begin
		{ref_clk, rst_b, lvd_trip, clk_lost, lpo_clk} = '0;
		{low_voltage_reset_en, background_halt_allow} = '0;
		{illegal_opcode, illegal_address, stop_exec, debug_halt_instr} = '0;
		{reg_wr, reg_rd, reg_bdm, reg_addr} = '0;
		ext_reset_pin_b = 1'b1;
		reg_wdata = 8'h00;
		fail_count = 0;
		n_tests = 0;
		repeat (5) @(negedge ref_clk);
		rst_b = 1'b1;
		wait_run();
		rdc(2'h0, 8'h82, "cause after power-on");
		rdc(2'h2, 8'hc0, "options once reset");
		rdc(2'h3, 8'h00, "options two reset");
		rdc(2'h1, 8'h00, "force reg read");
		wr(2'h1, 8'h01, 1'b0);
		repeat (4) @(negedge ref_clk);
		chkb("user force ignored", 1'b1, mcu_rst_b);
		// Options lock on first write; watchdog off with timeout zero
		wr(2'h2, 8'h28, 1'b0);
		rdc(2'h2, 8'h28, "options first write");
		chkb("twi route", 1'b1, twi_pin_route);
		wr(2'h2, 8'hff, 1'b0);
		rdc(2'h2, 8'h28, "options second write");
		wr(2'h3, 8'h80, 1'b0);
		wr(2'h3, 8'h40, 1'b0);
		rdc(2'h3, 8'h80, "options two lock");
		wr(2'h0, 8'h12, 1'b0);
		repeat (300) @(negedge ref_clk);
		chkb("watchdog disabled", 1'b1, mcu_rst_b);
		fire(2);
		chkb("stop allowed", 1'b1, seen_stop);
		background_halt_allow = 1'b1;
		fire(3);
		chkb("halt allowed", 1'b1, seen_halt);
		fire(5);
		chkb("lvd gated", 1'b1, mcu_rst_b);
		wr(2'h1, 8'h01, 1'b1);
		wait_rst(2);
		wait_run();
		rdc(2'h0, 8'h00, "cause after force");
		rdc(2'h2, 8'hc0, "options after reset");
		chkb("twi route reset", 1'b0, twi_pin_route);
		// Each reset source in turn, flags show only that source
		background_halt_allow = 1'b0;
		low_voltage_reset_en = 1'b1;
		for (int k = 0; k < 7; k++) begin
			fire(k);
			if (k == 2)
				chkb("stop refused", 1'b0, seen_stop);
			wait_rst(8);
			wait_run();
			rdc(2'h0, exp_c[k], "cause per source");
		end
		// Service keeps flags; lone 0xaa is harmless; other values reset
		svc();
		rdc(2'h0, 8'h40, "cause after service");
		wr(2'h0, 8'haa, 1'b0);
		repeat (4) @(negedge ref_clk);
		chkb("lone second byte", 1'b1, mcu_rst_b);
		wr(2'h0, 8'h12, 1'b0);
		wait_rst(2);
		wait_run();
		rdc(2'h0, 8'h20, "cause bad service");
		// Bus clock overflow per timeout code, timed from a service
		for (int c = 1; c < 4; c++) begin
			wr(2'h3, 8'h80, 1'b0);
			wr(2'h2, {c[1:0], 6'h00}, 1'b0);
			svc();
			wd_time(n);
			chkr("bus overflow", (32 << c) - 2, (32 << c) + 4, n);
			wait_run();
			rdc(2'h0, 8'h20, "cause overflow");
		end
		// Slow clock overflow per code; a tick is 326 ns here
		for (int c = 1; c < 4; c++) begin
			wr(2'h2, {c[1:0], 6'h00}, 1'b0);
			svc();
			wd_time(n);
			chkr("slow overflow", (c == 1 ? 32 : c == 2 ? 256 : 1024) * 326 / 40 - 20,
				(c == 1 ? 32 : c == 2 ? 256 : 1024) * 326 / 40 + 20, n);
			wait_run();
		end
		// Window mode: early write resets, late service restarts
		wr(2'h3, 8'hc0, 1'b0);
		wr(2'h2, 8'h40, 1'b0);
		wr(2'h0, 8'h55, 1'b0);
		wait_rst(2);
		wait_run();
		rdc(2'h0, 8'h20, "cause early write");
		wr(2'h3, 8'hc0, 1'b0);
		wr(2'h2, 8'h40, 1'b0);
		repeat (50) @(negedge ref_clk);
		svc();
		chkb("service in window", 1'b1, mcu_rst_b);
		wd_time(n);
		chkr("window overflow", 62, 68, n);
		give_verdict();
	end
endmodule
